// [adc_reg_bank.sv]
/*
 * Register bank and alert comparator of a 12-bit converter.
 * Link side runs on link_clk and receives framed bytes from the
 * two-wire front end; the registers and comparator run on ref_clk.
 * Assumes the analog core raises conv_done for one ref_clk cycle.
 */
// What this block does
// - Select byte low bits pick register.
// - Result holds 12-bit code, low nibble zero.
// - Result reads zero until first conversion.
// - Start bit begins conversion only when idle.
// - Start bit reads zero while converting.
// - Setup bits 14:12 choose input pair.
// - Setup bits 11:9 choose full scale.
// - Bit 8 selects continuous or single-shot.
// - Bits 7:5 choose conversion rate.
// - Bit 4 selects traditional or window comparator.
// - Bit 3 sets alert pin polarity.
// - Latched alert holds until result read, response or queue set to 11.
// - Queue needs 1,2,4 hits; 11 disables.
// - Compare ignores threshold low nibble.
// - High MSB set, low clear: ready.
// - Write frame: select, then MSB, LSB.
// - Reads use last select written.
`timescale 1ns/1ps
`default_nettype none

module adc_reg_bank
	import adc_regs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic link_clk,
	input wire logic frame_start,
	input wire logic frame_read,
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	output logic wr_ready,
	input wire logic rd_next,
	output logic rd_ready,
	output logic [7:0] rd_data,
	input wire logic alert_resp,
	input wire logic conv_done,
	input wire logic [11:0] conv_data,
	output logic conv_run,
	output logic [2:0] input_pair_select,
	output logic [2:0] gain_select,
	output logic [2:0] rate_select,
	output logic alert_pin
);

	// Link domain state
	logic [1:0] sel_reg;
	logic [1:0] byte_cnt_reg;
	logic [7:0] msb_hold_reg;
	logic lsb_next_reg;
	logic [7:0] lsb_hold_reg;
	logic req_send;
	logic [REQ_W-1:0] req_word;
	logic req_busy;
	logic ans_valid;
	logic [15:0] ans_word;

	// Core domain state
	logic [14:0] setup_reg;
	logic [15:0] low_reg, high_reg, result_reg;
	logic busy_reg;
	logic [2:0] hit_reg;
	logic alert_reg;
	logic [10:0] pulse_reg;
	logic req_valid;
	logic [REQ_W-1:0] req_data;
	logic resp_evt;
	logic ans_send;
	logic [15:0] ans_data;

	function automatic logic [2:0] hits_needed(input logic [1:0] q);
		unique case (q)
			QUEUE_ONE: hits_needed = 3'h1;
			QUEUE_TWO: hits_needed = 3'h2;
			default: hits_needed = 3'h4;
		endcase
	endfunction

	// Signed compare on significant bits only
	function automatic logic above(input logic [15:0] a, input logic [15:0] b);
		above = $signed(a & LEVEL_MASK) > $signed(b & LEVEL_MASK);
	endfunction

	// ---------------- Link domain ----------------

	// Write frames: select byte, then MSB and LSB of the word
	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			sel_reg <= SEL_RESULT;
			byte_cnt_reg <= BYTE_SEL;
			msb_hold_reg <= 8'h00;
		end else if (frame_start) begin
			byte_cnt_reg <= BYTE_SEL;
		end else if (wr_valid && wr_ready && byte_cnt_reg != BYTE_DONE) begin
			byte_cnt_reg <= byte_cnt_reg + 2'h1;
			if (byte_cnt_reg == BYTE_SEL) begin
				sel_reg <= wr_data[1:0];
			end
			if (byte_cnt_reg == BYTE_MSB) begin
				msb_hold_reg <= wr_data;
			end
		end
	end

	// Whole word after the LSB, read request at a read frame start
	always_comb begin
		req_send = 1'b0;
		req_word = {1'b0, sel_reg, 16'h0000};
		if (frame_start && frame_read) begin
			req_send = 1'b1;
		end else if (wr_valid && byte_cnt_reg == BYTE_LSB) begin
			req_send = 1'b1;
			req_word = {1'b1, sel_reg, msb_hold_reg, wr_data};
		end
	end

	assign wr_ready = !req_busy;

	word_crossing #(.W(REQ_W)) req_cross (
		.nrst(nrst),
		.src_clk(link_clk),
		.src_send(req_send),
		.src_data(req_word),
		.src_busy(req_busy),
		.dst_clk(ref_clk),
		.dst_valid(req_valid),
		.dst_data(req_data)
	);

	word_crossing #(.W(1)) resp_cross (
		.nrst(nrst),
		.src_clk(link_clk),
		.src_send(alert_resp),
		.src_data(1'b1),
		.src_busy(),
		.dst_clk(ref_clk),
		.dst_valid(resp_evt),
		.dst_data()
	);

	word_crossing #(.W(16)) ans_cross (
		.nrst(nrst),
		.src_clk(ref_clk),
		.src_send(ans_send),
		.src_data(ans_data),
		.src_busy(),
		.dst_clk(link_clk),
		.dst_valid(ans_valid),
		.dst_data(ans_word)
	);

	// Read bytes: MSB first, then LSB
	always_ff @(posedge link_clk or negedge nrst) begin
		if (!nrst) begin
			rd_ready <= 1'b0;
			rd_data <= 8'h00;
			lsb_hold_reg <= 8'h00;
			lsb_next_reg <= 1'b0;
		end else if (frame_start) begin
			rd_ready <= 1'b0;
		end else if (ans_valid) begin
			rd_ready <= 1'b1;
			rd_data <= ans_word[15:8];
			lsb_hold_reg <= ans_word[7:0];
			lsb_next_reg <= 1'b1;
		end else if (rd_next && rd_ready) begin
			rd_data <= lsb_next_reg ? lsb_hold_reg : 8'h00;
			lsb_next_reg <= 1'b0;
		end
	end

	// ---------------- Core domain ----------------

	logic wr_evt, rd_evt;
	logic [1:0] req_sel;
	logic [15:0] req_val;
	logic powered_down, start_req, ready_mode, single;
	logic over, under, outside, release_ok, hit_full;
	logic [1:0] queue;
	logic [15:0] new_result;

	assign wr_evt = req_valid && req_data[REQ_KIND];
	assign rd_evt = req_valid && !req_data[REQ_KIND];
	assign req_sel = req_data[17:16];
	assign req_val = req_data[15:0];
	assign single = setup_reg[MODE_BIT];
	assign queue = setup_reg[QUEUE_HI:QUEUE_LO];
	assign powered_down = single && !busy_reg;
	assign start_req = wr_evt && req_sel == SEL_SETUP
		&& req_val[START_BIT] && powered_down;
	assign ready_mode = high_reg[SIGN_BIT] && !low_reg[SIGN_BIT];

	// Writable registers; the start bit is an action, never stored
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			setup_reg <= SETUP_RST[14:0];
			low_reg <= LOW_RST;
			high_reg <= HIGH_RST;
		end else if (wr_evt) begin
			unique case (req_sel)
				SEL_SETUP: setup_reg <= req_val[14:0];
				SEL_LOW: low_reg <= req_val;
				SEL_HIGH: high_reg <= req_val;
				SEL_RESULT: ; // Result is read-only
			endcase
		end
	end

	// Setup fields steering the analog core
	assign input_pair_select = setup_reg[PAIR_HI:PAIR_LO];
	assign gain_select = setup_reg[GAIN_HI:GAIN_LO];
	assign rate_select = setup_reg[RATE_HI:RATE_LO];

	// Conversion activity: continuous always busy, single-shot on start
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			busy_reg <= 1'b0;
		end else if (!single) begin
			busy_reg <= 1'b1;
		end else if (start_req) begin
			busy_reg <= 1'b1;
		end else if (conv_done) begin
			busy_reg <= 1'b0;
		end
	end

	assign conv_run = busy_reg;

	// Result register: cleared at reset, loaded on each conversion
	assign new_result = {conv_data, NIBBLE_ZERO};
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			result_reg <= RESULT_RST;
		end else if (conv_done) begin
			result_reg <= new_result;
		end
	end

	// Read answer: the start bit shows idle as one
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ans_send <= 1'b0;
			ans_data <= 16'h0000;
		end else begin
			ans_send <= rd_evt;
			if (rd_evt) begin
				unique case (req_sel)
					SEL_RESULT: ans_data <= result_reg;
					SEL_SETUP: ans_data <= {!busy_reg, setup_reg};
					SEL_LOW: ans_data <= low_reg;
					SEL_HIGH: ans_data <= high_reg;
				endcase
			end
		end
	end

	// Threshold tests on the fresh result
	assign over = above(new_result, high_reg);
	assign under = above(low_reg, new_result);
	assign outside = over || (setup_reg[WINDOW_BIT] && under);
	assign release_ok = setup_reg[WINDOW_BIT] ? !(over || under) : under;
	assign hit_full = hit_reg + 3'h1 >= hits_needed(queue);

	// Successive out-of-limit count
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hit_reg <= 3'h0;
		end else if (wr_evt && req_sel == SEL_SETUP) begin
			hit_reg <= 3'h0;
		end else if (conv_done) begin
			if (!outside) begin
				hit_reg <= 3'h0;
			end else if (!hit_full) begin
				hit_reg <= hit_reg + 3'h1;
			end
		end
	end

	// Alert state; a new hit wins over a clearing read or response
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			alert_reg <= 1'b0;
		end else if (queue == QUEUE_OFF) begin
			alert_reg <= 1'b0;
		end else if (conv_done && outside && hit_full) begin
			alert_reg <= 1'b1;
		end else if (setup_reg[LATCH_BIT]) begin
			if ((rd_evt && req_sel == SEL_RESULT) || resp_evt) begin
				alert_reg <= 1'b0;
			end
		end else if (conv_done && release_ok) begin
			alert_reg <= 1'b0;
		end
	end

	// Ready pulse per result in continuous mode
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pulse_reg <= 11'h000;
		end else if (conv_done && !single) begin
			pulse_reg <= 11'(READY_PULSE_CYC);
		end else if (pulse_reg != 11'h000) begin
			pulse_reg <= pulse_reg - 11'h001;
		end
	end

	// Pin level with polarity; held high while disabled
	logic active;
	assign active = ready_mode ? (single ? !busy_reg : pulse_reg != 11'h000)
		: alert_reg;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			alert_pin <= 1'b1;
		end else if (queue == QUEUE_OFF) begin
			alert_pin <= 1'b1;
		end else begin
			alert_pin <= setup_reg[POL_BIT] ? active : !active;
		end
	end

	// ---------------- Checks ----------------

	sequence start_write_s;
		wr_evt && req_sel == SEL_SETUP && req_val[START_BIT] && powered_down;
	endsequence

	// A finished conversion above the high limit, or below the low limit in window mode
	sequence conv_finish_s;
		conv_done && outside;
	endsequence

	start_sets_busy_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		start_write_s |=> busy_reg && conv_run)
		else $error("start while idle did not begin conversion");
	idle_status_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		rd_evt && req_sel == SEL_SETUP |=> ans_data[START_BIT] == !$past(busy_reg))
		else $error("start bit read does not show idle state");
	result_load_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		conv_done |=> result_reg == {$past(conv_data), NIBBLE_ZERO})
		else $error("result not loaded from conversion");
	result_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		!conv_done |=> $stable(result_reg))
		else $error("result changed without conversion");
	disabled_high_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		queue == QUEUE_OFF |=> alert_pin && !alert_reg)
		else $error("disabled comparator pin not high");
	single_hit_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		conv_finish_s ##0 (queue == QUEUE_ONE) |=> alert_reg)
		else $error("single hit did not raise alert");
	latch_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		alert_reg && setup_reg[LATCH_BIT] && queue != QUEUE_OFF && !resp_evt
		&& !(rd_evt && req_sel == SEL_RESULT) |=> alert_reg)
		else $error("latched alert dropped without clear");
	pin_polarity_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		!ready_mode && queue != QUEUE_OFF && $stable(queue)
		##1 $stable(alert_reg) && $stable(setup_reg[POL_BIT])
		|-> alert_pin == (setup_reg[POL_BIT] ? alert_reg : !alert_reg))
		else $error("pin level does not follow polarity");
	hit_restart_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		conv_done && !outside |=> hit_reg == 3'h0)
		else $error("hit count not restarted inside limits");
	ready_single_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ready_mode && single && queue != QUEUE_OFF && !setup_reg[POL_BIT]
		|=> alert_pin == $past(busy_reg))
		else $error("ready pin does not follow status");

endmodule

`default_nettype wire

// [adc_regs_pkg.sv]
/*
 * Constants for the converter register bank and alert comparator:
 * register selects, field positions, reset values and timing counts.
 * Assumes a 200 MHz core clock.
 */
package adc_regs_pkg;

	// Register selects carried in the low two bits of the select byte
	localparam logic [1:0] SEL_RESULT = 2'h0;
	localparam logic [1:0] SEL_SETUP = 2'h1;
	localparam logic [1:0] SEL_LOW = 2'h2;
	localparam logic [1:0] SEL_HIGH = 2'h3;

	// Reset values
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic [15:0] SETUP_RST = 16'h8583;
	localparam logic [15:0] LOW_RST = 16'h8000;
	localparam logic [15:0] HIGH_RST = 16'h7fff;

	// Field positions inside operating_setup
	localparam int START_BIT = 15;
	localparam int PAIR_HI = 14;
	localparam int PAIR_LO = 12;
	localparam int GAIN_HI = 11;
	localparam int GAIN_LO = 9;
	localparam int MODE_BIT = 8;
	localparam int RATE_HI = 7;
	localparam int RATE_LO = 5;
	localparam int WINDOW_BIT = 4;
	localparam int POL_BIT = 3;
	localparam int LATCH_BIT = 2;
	localparam int QUEUE_HI = 1;
	localparam int QUEUE_LO = 0;
	localparam int SIGN_BIT = 15;

	// Queue codes
	localparam logic [1:0] QUEUE_ONE = 2'h0;
	localparam logic [1:0] QUEUE_TWO = 2'h1;
	localparam logic [1:0] QUEUE_FOUR = 2'h2;
	localparam logic [1:0] QUEUE_OFF = 2'h3;

	// Low nibble of results and thresholds is never significant
	localparam logic [15:0] LEVEL_MASK = 16'hfff0;
	localparam logic [3:0] NIBBLE_ZERO = 4'h0;

	// Byte positions within a write frame
	localparam logic [1:0] BYTE_SEL = 2'h0;
	localparam logic [1:0] BYTE_MSB = 2'h1;
	localparam logic [1:0] BYTE_LSB = 2'h2;
	localparam logic [1:0] BYTE_DONE = 2'h3;

	// Ready pulse width in continuous mode
	localparam int CLK_PERIOD_PS = 5000;
	localparam int READY_PULSE_NS = 8000;
	localparam int READY_PULSE_CYC =
		(READY_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Request word crossing from link to core: kind, select, data
	localparam int REQ_W = 19;
	localparam int REQ_KIND = 18;

endpackage

// [word_crossing.sv]
/*
 * Toggle handshake carrying one word from one clock domain to another.
 * Assumes the source raises src_send only while src_busy is low.
 */
`timescale 1ns/1ps
`default_nettype none

module word_crossing #(
	parameter int W = 16
) (
	input wire logic nrst,
	input wire logic src_clk,
	input wire logic src_send,
	input wire logic [W-1:0] src_data,
	output logic src_busy,
	input wire logic dst_clk,
	output logic dst_valid,
	output logic [W-1:0] dst_data
);

	logic tgl_reg;
	logic [W-1:0] hold_reg;
	logic s1_reg, s2_reg, s3_reg;
	logic a1_reg, a2_reg;

	// Source side: hold the word and flip the toggle
	always_ff @(posedge src_clk or negedge nrst) begin
		if (!nrst) begin
			tgl_reg <= 1'b0;
			hold_reg <= '0;
		end else if (src_send && !src_busy) begin
			tgl_reg <= ~tgl_reg;
			hold_reg <= src_data;
		end
	end

	// Acknowledge returns to the source through two flops
	always_ff @(posedge src_clk or negedge nrst) begin
		if (!nrst) begin
			a1_reg <= 1'b0;
			a2_reg <= 1'b0;
		end else begin
			a1_reg <= s3_reg;
			a2_reg <= a1_reg;
		end
	end

	assign src_busy = tgl_reg ^ a2_reg;

	// Destination side: synchronise toggle, take word on its change
	always_ff @(posedge dst_clk or negedge nrst) begin
		if (!nrst) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			dst_valid <= 1'b0;
			dst_data <= '0;
		end else begin
			s1_reg <= tgl_reg;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			dst_valid <= s2_reg ^ s3_reg;
			if (s2_reg ^ s3_reg) begin
				dst_data <= hold_reg;
			end
		end
	end

	// The held word must not move while a transfer is in flight
	hold_stable_a: assert property (@(posedge src_clk) disable iff (!nrst)
		src_busy |=> $stable(hold_reg))
		else $error("crossing word changed while in flight");

endmodule

`default_nettype wire

// [adc_core_model.sv]
/*
 * Behavioural analog core beside the register bank.
 * Assumes conv_run from the bank and a code chosen by the bench.
 */
`timescale 1ns/1ps
`default_nettype none

module adc_core_model #(
	parameter int DELAY = 600
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic conv_run,
	input wire logic [11:0] code,
	output logic conv_done,
	output logic [11:0] conv_data
);
	int cnt;

	// Count while asked to convert, then hand over one code
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 0;
			conv_done <= 1'b0;
			conv_data <= 12'h000;
		end else if (conv_run && cnt == DELAY && !conv_done) begin
			cnt <= 0;
			conv_done <= 1'b1;
			conv_data <= code;
		end else begin
			cnt <= conv_run ? cnt + 1 : 0;
			conv_done <= 1'b0;
			conv_data <= ~code; // No stale code between results
		end
	end
endmodule
`default_nettype wire

// [tb.sv]
/*
 * Self-checking bench for the register bank: link frames and a core model.
 * Assumes the link clock is free of the core clock in phase.
 */
`timescale 1ns/1ps
`default_nettype none

module tb
	import adc_regs_pkg::*;
;
	logic ref_clk, link_clk, nrst;
	logic frame_start, frame_read, wr_valid, rd_next, alert_resp;
	logic wr_ready, rd_ready, conv_done, conv_run, alert_pin;
	logic [7:0] wr_data, rd_data;
	logic [11:0] conv_data, code;
	logic [2:0] pair, gain, rate;
	logic [15:0] val, s;
	int error_cnt, n_tests, cycles;

	adc_reg_bank DUT (.ref_clk(ref_clk), .nrst(nrst), .link_clk(link_clk),
		.frame_start(frame_start), .frame_read(frame_read),
		.wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
		.rd_next(rd_next), .rd_ready(rd_ready), .rd_data(rd_data),
		.alert_resp(alert_resp), .conv_done(conv_done),
		.conv_data(conv_data), .conv_run(conv_run),
		.input_pair_select(pair), .gain_select(gain),
		.rate_select(rate), .alert_pin(alert_pin));

	adc_core_model #(.DELAY(600)) core (.ref_clk(ref_clk), .nrst(nrst),
		.conv_run(conv_run), .code(code), .conv_done(conv_done),
		.conv_data(conv_data));

	// Clocks with unrelated phase
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end

	// Hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			error_cnt++;
			summarize();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		if (error_cnt == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic lpulse(input bit rd, input bit resp);
		@(posedge link_clk);
		frame_start <= !resp;
		frame_read <= rd;
		alert_resp <= resp;
		@(posedge link_clk);
		frame_start <= 1'b0;
		alert_resp <= 1'b0;
	endtask

	// One byte, held until the bank accepts it
	task automatic send(input logic [7:0] b);
		@(posedge link_clk);
		wr_valid <= 1'b1;
		wr_data <= b;
		@(negedge link_clk);
		while (!wr_ready)
			@(negedge link_clk);
		@(posedge link_clk);
		wr_valid <= 1'b0;
	endtask

	task automatic wr(input logic [1:0] sel, input logic [15:0] d,
		input bit full);
		lpulse(1'b0, 1'b0);
		send({6'h00, sel});
		if (full) begin
			send(d[15:8]);
			send(d[7:0]);
		end
		repeat (2) @(negedge link_clk);
		while (!wr_ready)
			@(negedge link_clk);
	endtask

	task automatic rd(input logic [1:0] sel, output logic [15:0] v);
		wr(sel, 16'h0000, 1'b0);
		lpulse(1'b1, 1'b0);
		@(negedge link_clk); // Ready of the previous frame is gone by now
		while (rd_ready !== 1'b1)
			@(negedge link_clk);
		v[15:8] = rd_data;
		@(posedge link_clk);
		rd_next <= 1'b1;
		@(posedge link_clk);
		rd_next <= 1'b0;
		@(negedge link_clk);
		v[7:0] = rd_data;
	endtask

	// Start one single-shot conversion and check the pin after it
	task automatic conv(input logic [15:0] st, input logic [11:0] c,
		input logic e);
		@(posedge ref_clk);
		code <= c;
		wr(SEL_SETUP, st, 1'b1);
		while (conv_run !== 1'b1)
			@(negedge ref_clk);
		while (conv_run === 1'b1)
			@(negedge ref_clk);
		repeat (8) @(negedge ref_clk);
		chk({15'h0000, alert_pin}, {15'h0000, e});
	endtask

	initial begin
		nrst = 1'b0;
		frame_start = 1'b0;
		frame_read = 1'b0;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		rd_next = 1'b0;
		alert_resp = 1'b0;
		code = 12'h000;
		repeat (6) @(posedge link_clk);
		nrst <= 1'b1;
		chk({15'h0000, alert_pin}, 16'h0001);
		chk({7'h00, pair, gain, rate},
			{7'h00, SETUP_RST[14:9], SETUP_RST[7:5]});
		rd(SEL_RESULT, val);
		chk(val, RESULT_RST);
		rd(SEL_SETUP, val);
		chk(val, SETUP_RST);
		rd(SEL_LOW, val);
		chk(val, LOW_RST);
		rd(SEL_HIGH, val);
		chk(val, HIGH_RST);
		// Every field code lands on its output and reads back
		for (int i = 0; i < 8; i++) begin
			s = {1'b0, i[2:0], i[2:0], 1'b1, i[2:0], 5'h03};
			wr(SEL_SETUP, s, 1'b1);
			chk({7'h00, pair, gain, rate}, {7'h00, s[14:9], s[7:5]});
			rd(SEL_SETUP, val);
			chk(val, s | 16'h8000);
		end
		// Status bit low only while converting
		wr(SEL_SETUP, SETUP_RST, 1'b1);
		chk({15'h0000, conv_run}, 16'h0001);
		rd(SEL_SETUP, val);
		chk(val, 16'h0583);
		// Low nibble of the low limit must not count in the compare
		wr(SEL_LOW, 16'h100f, 1'b1);
		wr(SEL_HIGH, 16'h2000, 1'b1);
		rd(SEL_HIGH, val);
		chk(val, 16'h2000);
		conv(16'h8588, 12'h300, 1'b1);
		rd(SEL_RESULT, val);
		chk(val, 16'h3000);
		conv(16'h8588, 12'h180, 1'b1);
		conv(16'h8588, 12'h080, 1'b0);
		conv(16'h8598, 12'h100, 1'b0);
		conv(16'h8598, 12'h080, 1'b1);
		conv(16'h8590, 12'h080, 1'b0);
		conv(16'h858c, 12'h300, 1'b1);
		conv(16'h858c, 12'h080, 1'b1);
		rd(SEL_RESULT, val);
		chk(val, 16'h0800);
		repeat (10) @(negedge ref_clk);
		chk({15'h0000, alert_pin}, 16'h0000);
		conv(16'h858c, 12'h300, 1'b1);
		lpulse(1'b0, 1'b1);
		repeat (20) @(negedge ref_clk);
		chk({15'h0000, alert_pin}, 16'h0000);
		// Ready use: active-low pin stays high while converting
		wr(SEL_LOW, 16'h0000, 1'b1);
		wr(SEL_HIGH, 16'h8000, 1'b1);
		wr(SEL_SETUP, 16'h8580, 1'b1);
		repeat (10) @(negedge ref_clk);
		chk({15'h0000, alert_pin}, 16'h0001);
		conv(16'h0580, 12'h7ff, 1'b0);
		// Continuous mode: always busy, ready pin pulses per result
		wr(SEL_SETUP, 16'h0480, 1'b1);
		chk({15'h0000, conv_run}, 16'h0001);
		chk({15'h0000, alert_pin}, 16'h0001);
		rd(SEL_SETUP, val);
		chk(val, 16'h0480);
		@(posedge conv_done);
		repeat (4) @(negedge ref_clk);
		chk({15'h0000, alert_pin}, 16'h0000);
		summarize();
	end
endmodule
`default_nettype wire
